// ---- pkg/lsr_pkg.sv ----
// package: constants, register map and types of the log sense responder
package lsr_pkg;
  localparam logic [7:0] LSR_OP_SENSE = 8'h4D;
  localparam logic [1:0] LSR_PC_CUMUL = 2'h1;
  localparam logic [1:0] LSR_FL_STOP = 2'h0;
  localparam logic [1:0] LSR_FL_ASCII = 2'h1;
  localparam logic [1:0] LSR_FL_RUN = 2'h2;
  localparam logic [1:0] LSR_FL_BIN = 2'h3;
  localparam logic [15:0] LSR_HDR_LEN = 16'h0004;
  localparam logic [15:0] LSR_P0_LEN = 16'h0011;
  localparam logic [7:0] LSR_PVAL_LEN = 8'h08;
  localparam logic [3:0] LSR_PHDR_LEN = 4'h4;
  localparam logic [3:0] LSR_PARM_LAST = 4'hB;
  localparam int LSR_CNT_W = 64;
  localparam int LSR_NUM_PAGES = 17;
  localparam logic [7:0] LSR_PAGES [LSR_NUM_PAGES] = '{
    8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h0D, 8'h0E, 8'h0F,
    8'h10, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h2F, 8'h30, 8'h37};
  localparam logic [3:0] LSR_SK_ILLEGAL = 4'h5;
  localparam logic [7:0] LSR_ASC_FIELD = 8'h24;
  localparam logic [7:0] LSR_ASC_OPCODE = 8'h20;
  localparam logic [7:0] LSR_OFF_CTRL = 8'h00;
  localparam logic [7:0] LSR_OFF_CDB0 = 8'h04;
  localparam logic [7:0] LSR_OFF_CDB1 = 8'h08;
  localparam logic [7:0] LSR_OFF_CDB2 = 8'h0C;
  localparam logic [7:0] LSR_OFF_STAT = 8'h10;
  localparam logic [7:0] LSR_OFF_FLCFG = 8'h14;
  localparam logic [7:0] LSR_OFF_XFER = 8'h18;
  localparam int LSR_CTRL_GO = 0;
  localparam int LSR_CTRL_CLR = 1;
  localparam int LSR_CTRL_LIST = 2;
  localparam int LSR_ST_UA = 3;
  localparam logic [31:0] LSR_CDB_RST = 32'h0000_0000;
  localparam logic [31:0] LSR_FL_RST = 32'h0000_0000;
  localparam logic [1:0] LSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] LSR_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LSR_IDLE, LSR_CHECK, LSR_SEND} lsr_state_type;
endpackage : lsr_pkg

// ---- hw/lsr_counters.sv ----
// log counters with format-and-linking saturation behaviour
`timescale 1ns/10ps
module lsr_counters #(
  parameter int N = 4
) (
  input logic mclk,
  input logic rst,
  input logic [N-1:0] evt,
  input logic [N-1:0][1:0] fl,
  input logic clear,
  output logic [N-1:0][lsr_pkg::LSR_CNT_W-1:0] val
);
  localparam int W = lsr_pkg::LSR_CNT_W;
  logic [N-1:0] sat;
  logic [N-1:0] frozen_q;

  for (genvar i = 0; i < N; i++) begin : g_cnt
    wire other_sat = |(sat & ~(N'(1) << i));
    wire is_stop = fl[i] == lsr_pkg::LSR_FL_STOP;
    wire is_run = fl[i] == lsr_pkg::LSR_FL_RUN;
    // lists never saturate and are not counted here
    wire bump = evt[i] && !sat[i] &&
      ((is_stop && !frozen_q[i] && !other_sat) || is_run);
    assign sat[i] = &val[i];
    always_ff @(posedge mclk) begin
      if (rst || clear) begin
        val[i] <= '0;
        frozen_q[i] <= 1'b0;
      end else begin
        if (bump) begin
          val[i] <= val[i] + {{(W-1){1'b0}}, 1'b1};
        end
        if (is_stop && other_sat) begin
          frozen_q[i] <= 1'b1;
        end
      end
    end
    a_freeze_stop: assert property (@(posedge mclk) disable iff (rst)
      (is_stop && other_sat && !clear) |=> $stable(val[i]))
      else $error("stop counter moved after another saturated");
    a_run_keeps: assert property (@(posedge mclk) disable iff (rst)
      (is_run && evt[i] && !sat[i] && !clear) |=> val[i] == $past(val[i]) + 1)
      else $error("run counter did not count");
  end
endmodule : lsr_counters

// ---- hw/lsr_responder.sv ----
// log sense command decoder and data-in streamer behind an axi4-lite slave
`timescale 1ns/10ps
module lsr_responder #(
  parameter int N_CNT = 4,
  parameter logic [5:0] CNT_PAGE = 6'h02
) (
  input logic mclk,
  input logic rst,
  input logic [7:0] s_awaddr,
  input logic s_awvalid,
  output logic s_awready,
  input logic [31:0] s_wdata,
  input logic [3:0] s_wstrb,
  input logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input logic s_bready,
  input logic [7:0] s_araddr,
  input logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input logic s_rready,
  output logic [7:0] din_data,
  output logic din_valid,
  input logic din_ready,
  output logic din_last,
  input logic [N_CNT-1:0] cnt_evt,
  output logic save_req,
  output logic unit_attn
);
  localparam logic [15:0] NC16 = 16'(N_CNT);

  function automatic logic [31:0] lsr_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : lsr_merge

  function automatic logic lsr_listed(input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < lsr_pkg::LSR_NUM_PAGES; k++) begin
      if (lsr_pkg::LSR_PAGES[k] == {2'b00, code}) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : lsr_listed

  lsr_pkg::lsr_state_type st_q;
  logic aw_hold_q;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] cdb0_q;
  logic [31:0] cdb1_q;
  logic [15:0] cdb2_q;
  logic [31:0] fl_q;
  logic list_q;
  logic done_q;
  logic check_q;
  logic ua_q;
  logic [3:0] sk_q;
  logic [7:0] asc_q;
  logic save_q;
  logic [15:0] cnt_q;
  logic [7:0] par_q;
  logic [3:0] off_q;
  logic [7:0] data_q;
  logic vld_q;
  logic last_q;
  logic ctl_q;
  logic [N_CNT-1:0][lsr_pkg::LSR_CNT_W-1:0] cval;
  logic [N_CNT-1:0][1:0] fl_vec;

  // bus handshakes
  assign s_awready = !aw_hold_q && !bvalid_q;
  assign s_wready = !w_hold_q && !bvalid_q;
  assign s_arready = !rvalid_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;
  wire wr_go = aw_hold_q && w_hold_q;
  wire rd_go = s_arvalid && s_arready;
  wire idle = st_q == lsr_pkg::LSR_IDLE;

  // write decode; command bytes are frozen while a command runs
  wire wa_ctrl = aw_addr_q == lsr_pkg::LSR_OFF_CTRL;
  wire wa_cdb0 = aw_addr_q == lsr_pkg::LSR_OFF_CDB0;
  wire wa_cdb1 = aw_addr_q == lsr_pkg::LSR_OFF_CDB1;
  wire wa_cdb2 = aw_addr_q == lsr_pkg::LSR_OFF_CDB2;
  wire wa_stat = aw_addr_q == lsr_pkg::LSR_OFF_STAT;
  wire wa_fl = aw_addr_q == lsr_pkg::LSR_OFF_FLCFG;
  wire wa_xfer = aw_addr_q == lsr_pkg::LSR_OFF_XFER;
  wire wr_map = wa_ctrl || wa_cdb0 || wa_cdb1 || wa_cdb2 ||
    wa_stat || wa_fl || wa_xfer;
  wire wr_ctrl0 = wr_go && wa_ctrl && w_strb_q[0];
  wire go = wr_ctrl0 && w_data_q[lsr_pkg::LSR_CTRL_GO] && idle;
  wire log_clr = wr_ctrl0 && w_data_q[lsr_pkg::LSR_CTRL_CLR];
  wire ua_wclr = wr_go && wa_stat && w_strb_q[0] &&
    w_data_q[lsr_pkg::LSR_ST_UA];
  wire wr_cdb = wr_go && idle;
  wire [31:0] cdb2_m = lsr_merge({16'h0000, cdb2_q}, w_data_q, w_strb_q);

  // read decode
  wire [31:0] stat_w = {8'h00, asc_q, 4'h0, sk_q,
    4'h0, ua_q, check_q, done_q, !idle};
  wire ra_ctrl = s_araddr == lsr_pkg::LSR_OFF_CTRL;
  wire ra_cdb0 = s_araddr == lsr_pkg::LSR_OFF_CDB0;
  wire ra_cdb1 = s_araddr == lsr_pkg::LSR_OFF_CDB1;
  wire ra_cdb2 = s_araddr == lsr_pkg::LSR_OFF_CDB2;
  wire ra_stat = s_araddr == lsr_pkg::LSR_OFF_STAT;
  wire ra_fl = s_araddr == lsr_pkg::LSR_OFF_FLCFG;
  wire ra_xfer = s_araddr == lsr_pkg::LSR_OFF_XFER;
  wire rd_map = ra_ctrl || ra_cdb0 || ra_cdb1 || ra_cdb2 ||
    ra_stat || ra_fl || ra_xfer;
  wire [31:0] rd_mux =
    ra_ctrl ? {29'h0, list_q, 2'b00} :
    ra_cdb0 ? cdb0_q :
    ra_cdb1 ? cdb1_q :
    ra_cdb2 ? {16'h0000, cdb2_q} :
    ra_stat ? stat_w :
    ra_fl ? fl_q :
    ra_xfer ? {16'h0000, cnt_q} : 32'h0000_0000;

  // command fields, byte n of the block sits in lane n mod 4
  wire [7:0] op = cdb0_q[7:0];
  wire sp = cdb0_q[8];
  wire [1:0] pc = cdb0_q[23:22];
  wire [5:0] pg = cdb0_q[21:16];
  wire [15:0] ptr = {cdb1_q[15:8], cdb1_q[23:16]};
  wire [15:0] alloc = {cdb1_q[31:24], cdb2_q[7:0]};
  wire op_bad = op != lsr_pkg::LSR_OP_SENSE;
  wire pc_bad = pc != lsr_pkg::LSR_PC_CUMUL;
  wire pg_bad = !list_q && !lsr_listed(pg);
  wire cmd_bad = op_bad || pc_bad || pg_bad;
  wire pg_is0 = !list_q && pg == 6'h00;
  wire pg_iscnt = list_q || pg == CNT_PAGE;
  wire [5:0] pg_out = pg_iscnt ? CNT_PAGE : pg;

  // lengths: pointer past the last code leaves an empty page
  wire [15:0] first16 = (ptr > NC16) ? NC16 : ptr;
  wire [15:0] npar = NC16 - first16;
  wire [15:0] plen = pg_is0 ? lsr_pkg::LSR_P0_LEN :
    pg_iscnt ? 16'((npar << 3) + (npar << 2)) : 16'h0000;
  wire [15:0] total = plen + lsr_pkg::LSR_HDR_LEN;
  wire [15:0] lim = (alloc < total) ? alloc : total;

  // byte selection
  wire [7:0] hdr_b = (cnt_q[1:0] == 2'd0) ? {2'b00, pg_out} :
    (cnt_q[1:0] == 2'd1) ? 8'h00 :
    (cnt_q[1:0] == 2'd2) ? plen[15:8] : plen[7:0];
  wire [15:0] idx16 = cnt_q - lsr_pkg::LSR_HDR_LEN;
  wire [7:0] list_b = lsr_pkg::LSR_PAGES[idx16[4:0]];
  assign fl_vec = fl_q[2*N_CNT-1:0];
  // du, tsd, etc and tmc all zero; only the linking code is live
  wire [7:0] ctl_b = {6'b000000, fl_vec[par_q]};
  wire [3:0] voff = off_q - lsr_pkg::LSR_PHDR_LEN;
  wire [lsr_pkg::LSR_CNT_W-1:0] vsh = cval[par_q] << {voff, 3'b000};
  wire [7:0] par_b = (off_q == 4'd0) ? 8'h00 :
    (off_q == 4'd1) ? par_q :
    (off_q == 4'd2) ? ctl_b :
    (off_q == 4'd3) ? lsr_pkg::LSR_PVAL_LEN :
    vsh[lsr_pkg::LSR_CNT_W-1 -: 8];
  wire in_hdr = cnt_q < lsr_pkg::LSR_HDR_LEN;
  wire [7:0] byte_nx = in_hdr ? hdr_b :
    pg_is0 ? list_b :
    pg_iscnt ? par_b : 8'h00;
  wire slot = !vld_q || din_ready;
  wire sending = st_q == lsr_pkg::LSR_SEND;
  wire load = sending && slot && cnt_q != lim;
  wire finish = sending && slot && cnt_q == lim;

  assign din_data = data_q;
  assign din_valid = vld_q;
  assign din_last = last_q;
  assign save_req = save_q;
  assign unit_attn = ua_q;

  lsr_counters #(
    .N(N_CNT)
  ) u_cnt (
    .mclk(mclk),
    .rst(rst),
    .evt(cnt_evt),
    .fl(fl_vec),
    .clear(log_clr),
    .val(cval)
  );

  // axi4-lite channels
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= lsr_pkg::LSR_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= lsr_pkg::LSR_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? lsr_pkg::LSR_RESP_OKAY
          : lsr_pkg::LSR_RESP_SLVERR;
      end else if (s_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_map ? lsr_pkg::LSR_RESP_OKAY
          : lsr_pkg::LSR_RESP_SLVERR;
      end else if (s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // software-written state
  always_ff @(posedge mclk) begin
    if (rst) begin
      cdb0_q <= lsr_pkg::LSR_CDB_RST;
      cdb1_q <= lsr_pkg::LSR_CDB_RST;
      cdb2_q <= lsr_pkg::LSR_CDB_RST[15:0];
      fl_q <= lsr_pkg::LSR_FL_RST;
      list_q <= 1'b0;
      ua_q <= 1'b0;
    end else begin
      if (wr_cdb && wa_cdb0) begin
        cdb0_q <= lsr_merge(cdb0_q, w_data_q, w_strb_q);
      end
      if (wr_cdb && wa_cdb1) begin
        cdb1_q <= lsr_merge(cdb1_q, w_data_q, w_strb_q);
      end
      if (wr_cdb && wa_cdb2) begin
        cdb2_q <= cdb2_m[15:0];
      end
      if (wr_cdb && wa_fl) begin
        fl_q <= lsr_merge(fl_q, w_data_q, w_strb_q);
      end
      if (wr_cdb && wa_ctrl && w_strb_q[0]) begin
        list_q <= w_data_q[lsr_pkg::LSR_CTRL_LIST];
      end
      // a new reset beats a software clear in the same cycle
      if (log_clr) begin
        ua_q <= 1'b1;
      end else if (ua_wclr) begin
        ua_q <= 1'b0;
      end
    end
  end

  // command sequencer and data-in stream
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= lsr_pkg::LSR_IDLE;
      done_q <= 1'b0;
      check_q <= 1'b0;
      sk_q <= 4'h0;
      asc_q <= 8'h00;
      save_q <= 1'b0;
      cnt_q <= 16'h0000;
      par_q <= 8'h00;
      off_q <= 4'h0;
      data_q <= 8'h00;
      vld_q <= 1'b0;
      last_q <= 1'b0;
      ctl_q <= 1'b0;
    end else begin
      save_q <= 1'b0;
      case (st_q)
        lsr_pkg::LSR_IDLE: begin
          if (go) begin
            st_q <= lsr_pkg::LSR_CHECK;
            done_q <= 1'b0;
            check_q <= 1'b0;
            sk_q <= 4'h0;
            asc_q <= 8'h00;
            cnt_q <= 16'h0000;
          end
        end
        lsr_pkg::LSR_CHECK: begin
          par_q <= first16[7:0];
          off_q <= 4'h0;
          if (cmd_bad) begin
            st_q <= lsr_pkg::LSR_IDLE;
            done_q <= 1'b1;
            check_q <= 1'b1;
            sk_q <= lsr_pkg::LSR_SK_ILLEGAL;
            asc_q <= op_bad ? lsr_pkg::LSR_ASC_OPCODE
              : lsr_pkg::LSR_ASC_FIELD;
          end else begin
            save_q <= sp;
            if (alloc == 16'h0000) begin
              st_q <= lsr_pkg::LSR_IDLE;
              done_q <= 1'b1;
            end else begin
              st_q <= lsr_pkg::LSR_SEND;
            end
          end
        end
        lsr_pkg::LSR_SEND: begin
          if (finish) begin
            st_q <= lsr_pkg::LSR_IDLE;
            done_q <= 1'b1;
          end
        end
        default: begin
          st_q <= lsr_pkg::LSR_IDLE;
        end
      endcase
      // counters may tick mid-value; bytes of a value are not snapshotted
      if (load) begin
        data_q <= byte_nx;
        vld_q <= 1'b1;
        last_q <= (cnt_q + 16'h0001) == lim;
        ctl_q <= !in_hdr && pg_iscnt && off_q == 4'd2;
        cnt_q <= cnt_q + 16'h0001;
        if (!in_hdr && pg_iscnt) begin
          if (off_q == lsr_pkg::LSR_PARM_LAST) begin
            off_q <= 4'h0;
            par_q <= par_q + 8'h01;
          end else begin
            off_q <= off_q + 4'h1;
          end
        end
      end else if (din_ready) begin
        vld_q <= 1'b0;
        last_q <= 1'b0;
      end
    end
  end

  wire chk = st_q == lsr_pkg::LSR_CHECK;
  a_opcode_chk: assert property (@(posedge mclk) disable iff (rst)
    (chk && op_bad) |=> check_q && asc_q == lsr_pkg::LSR_ASC_OPCODE)
    else $error("wrong opcode accepted");
  a_pc_chk: assert property (@(posedge mclk) disable iff (rst)
    (chk && !op_bad && pc_bad) |=> check_q &&
    sk_q == lsr_pkg::LSR_SK_ILLEGAL && asc_q == lsr_pkg::LSR_ASC_FIELD)
    else $error("page control not refused");
  a_page_chk: assert property (@(posedge mclk) disable iff (rst)
    (chk && !op_bad && !pc_bad && !list_q && !lsr_listed(pg))
    |=> check_q && !vld_q)
    else $error("unsupported page accepted");
  a_save_req: assert property (@(posedge mclk) disable iff (rst)
    (chk && !cmd_bad) |=> save_req == $past(sp))
    else $error("save request does not follow save bit");
  a_zero_alloc: assert property (@(posedge mclk) disable iff (rst)
    (chk && !cmd_bad && alloc == 16'h0000) |=> idle && done_q &&
    !check_q && cnt_q == 16'h0000 ##1 !din_valid)
    else $error("zero allocation moved data or failed");
  a_len_limit: assert property (@(posedge mclk) disable iff (rst)
    (din_valid && din_ready && din_last) |-> cnt_q == lim)
    else $error("transfer ended at wrong count");
  a_no_overrun: assert property (@(posedge mclk) disable iff (rst)
    sending |-> cnt_q <= lim)
    else $error("transfer ran past limit");
  a_hdr_code: assert property (@(posedge mclk) disable iff (rst)
    (din_valid && cnt_q == 16'h0001) |-> din_data == {2'b00, pg_out})
    else $error("page header code wrong");
  a_ctrl_zero: assert property (@(posedge mclk) disable iff (rst)
    (din_valid && ctl_q) |-> din_data[7:2] == 6'h00)
    else $error("control flags not zero");
  a_ua_post: assert property (@(posedge mclk) disable iff (rst)
    log_clr |=> unit_attn ##1 (unit_attn || $past(ua_wclr)))
    else $error("unit attention not posted");
endmodule : lsr_responder

// ---- sim/lsr_host_sink.sv ----
// initiator-side data-in sink with optional random stalls
`timescale 1ns/10ps
module lsr_host_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] din_data,
  input wire logic din_valid,
  input wire logic din_last,
  input wire logic slow,
  output logic din_ready
);
  logic [7:0] q [$];
  int last_at;
  initial begin
    din_ready = 1'b0;
    last_at = -1;
  end
  // bytes kept in arrival order, last flag position noted
  always @(posedge mclk) begin
    if (din_valid === 1'b1 && din_ready === 1'b1) begin
      if (din_last === 1'b1) last_at = q.size();
      q.push_back(din_data);
    end
    // stalls come at random so held data is exercised
    din_ready <= rst ? 1'b0 : (slow ? 1'($urandom_range(1)) : 1'b1);
  end
endmodule : lsr_host_sink

// ---- sim/log_sense_responder_tb.sv ----
// testbench: axi4-lite master, command model and data-in comparison
`timescale 1ns/10ps
module log_sense_responder_tb;
  logic mclk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr, din_data;
  logic [31:0] s_wdata, s_rdata, st, d;
  logic [3:0] s_wstrb, cnt_evt;
  logic [1:0] s_bresp, s_rresp, r;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic din_valid, din_ready, din_last, save_req, unit_attn, slow;
  logic [7:0] eq [$];
  logic [7:0] fl;
  logic [63:0] mc [4];
  int n_fail, checks, n_save, ns0, seed_v;
  logic [15:0] al;
  logic [7:0] eop [6] = '{8'h4C, 8'h4D, 8'h4D, 8'h4D, 8'h4D, 8'h4D};
  logic [1:0] epc [6] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [5:0] epg [6] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h01, 6'h3F};
  logic [7:0] easc [6] = '{8'h20, 8'h24, 8'h24, 8'h24, 8'h24, 8'h24};

  lsr_responder #(.N_CNT(4), .CNT_PAGE(6'h02)) DUT (.mclk(mclk), .rst(rst),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .din_data(din_data),
    .din_valid(din_valid), .din_ready(din_ready), .din_last(din_last),
    .cnt_evt(cnt_evt), .save_req(save_req), .unit_attn(unit_attn));
  lsr_host_sink SNK (.mclk(mclk), .rst(rst), .din_data(din_data),
    .din_valid(din_valid), .din_last(din_last), .slow(slow),
    .din_ready(din_ready));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) if (save_req === 1'b1) n_save++;
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    summarize();
  end

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ad, wd;
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    ad = 0;
    wd = 0;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (!ad && s_awready === 1'b1) begin ad = 1; s_awvalid <= 1'b0; end
      if (!wd && s_wready === 1'b1) begin wd = 1; s_wvalid <= 1'b0; end
    end
    do @(posedge mclk); while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge mclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge mclk); while (s_rvalid !== 1'b1);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask : axr

  // random event pulses, model counts only counter formats
  task automatic evts(input int n);
    logic [3:0] e;
    repeat (n) begin
      @(posedge mclk);
      e = 4'($urandom);
      cnt_evt <= e;
      for (int i = 0; i < 4; i++)
        if (e[i] && !fl[2*i]) mc[i]++;
    end
    @(posedge mclk);
    cnt_evt <= 4'h0;
  endtask : evts

  task automatic run(input logic [7:0] op, input bit sp, input logic [1:0] pc,
      input logic [5:0] pg, input logic [15:0] ptr, input bit lst);
    int t;
    SNK.q.delete();
    SNK.last_at = -1;
    axw(lsr_pkg::LSR_OFF_CDB0, {8'h00, pc, pg, 7'h00, sp, op}, r);
    axw(lsr_pkg::LSR_OFF_CDB1, {al[15:8], ptr[7:0], ptr[15:8], 8'h00}, r);
    axw(lsr_pkg::LSR_OFF_CDB2, {24'h000000, al[7:0]}, r);
    axw(lsr_pkg::LSR_OFF_CTRL, {29'h0, lst, 2'h1}, r);
    t = 0;
    do begin
      axr(lsr_pkg::LSR_OFF_STAT, st, r);
      t++;
    end while (!(st[1] === 1'b1 && st[0] === 1'b0) && t < 300);
    chk("done flag", 32'h1, {31'h0, st[1] && !st[0]});
  endtask : run

  task automatic exp_page(input logic [5:0] pg, input logic [15:0] ptr, input bit lst);
    int f, n;
    eq.delete();
    if (pg == 6'h00 && !lst) begin
      eq = '{8'h00, 8'h00, 8'h00, 8'h11};
      foreach (lsr_pkg::LSR_PAGES[i]) eq.push_back(lsr_pkg::LSR_PAGES[i]);
    end else if (pg == 6'h02 || lst) begin
      f = (ptr > 4) ? 4 : ptr;
      n = 12 * (4 - f);
      eq = '{8'h02, 8'h00, n[15:8], n[7:0]};
      for (int c = f; c < 4; c++) begin
        eq.push_back(8'h00);
        eq.push_back(c[7:0]);
        eq.push_back({6'h00, fl[2*c+:2]});
        eq.push_back(8'h08);
        for (int b = 7; b >= 0; b--) eq.push_back(mc[c][8*b+:8]);
      end
    end else
      eq = '{{2'h0, pg}, 8'h00, 8'h00, 8'h00};
    while (eq.size() > al) void'(eq.pop_back());
  endtask : exp_page

  task automatic chk_ok();
    chk("check flag", 32'h0, st[2]);
    chk("byte count", eq.size(), SNK.q.size());
    foreach (eq[i]) chk("data byte", eq[i], SNK.q[i]);
    chk("last position", eq.size() - 1, SNK.last_at);
    axr(lsr_pkg::LSR_OFF_XFER, d, r);
    chk("xfer", eq.size(), d);
  endtask : chk_ok

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, slow} = 6'h00;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, cnt_evt} = 56'h0;
    rst = 1'b1;
    fl = 8'h00;
    foreach (mc[i]) mc[i] = 64'h0;
    seed_v = $urandom(32'h0383CD2F);
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axr(lsr_pkg::LSR_OFF_STAT, d, r);
    chk("status reset", 32'h0, d);
    axr(lsr_pkg::LSR_OFF_CDB0, d, r);
    chk("cdb0 reset", lsr_pkg::LSR_CDB_RST, d);
    axr(lsr_pkg::LSR_OFF_FLCFG, d, r);
    chk("flcfg reset", lsr_pkg::LSR_FL_RST, d);
    axr(8'h1C, d, r);
    chk("rresp unmapped", lsr_pkg::LSR_RESP_SLVERR, r);
    chk("rdata unmapped", 32'h0, d);
    axw(8'h20, 32'h0, r);
    chk("bresp unmapped", lsr_pkg::LSR_RESP_SLVERR, r);
    for (int k = 0; k < 5; k++) begin
      al = (k == 0) ? 16'h0064 : 16'($urandom_range(25));
      slow = k[0];
      run(8'h4D, 0, 2'h1, 6'h00, 16'h0003, 0);
      exp_page(6'h00, 16'h0000, 0);
      chk_ok();
    end
    ns0 = n_save;
    al = 16'h0000;
    run(8'h4D, 1, 2'h1, 6'h30, 16'h0000, 0);
    eq.delete();
    chk_ok();
    chk("save pulses", ns0 + 1, n_save);
    ns0 = n_save;
    al = 16'h0010;
    run(8'h4D, 0, 2'h1, 6'h30, 16'h0000, 0);
    exp_page(6'h30, 16'h0000, 0);
    chk_ok();
    chk("save pulses", ns0, n_save);
    for (int k = 0; k < 6; k++) begin
      ns0 = n_save;
      al = 16'h0040;
      run(eop[k], 1, epc[k], epg[k], 16'h0000, 0);
      chk("check flag", 32'h1, st[2]);
      chk("sense key", lsr_pkg::LSR_SK_ILLEGAL, st[11:8]);
      chk("asc", easc[k], st[23:16]);
      chk("bytes on error", 32'h0, SNK.q.size());
      chk("save pulses", ns0, n_save);
    end
    fl = 8'hD8;
    axw(lsr_pkg::LSR_OFF_FLCFG, {24'h0, fl}, r);
    evts(200);
    slow = 1'b1;
    al = 16'h00C8;
    for (int p = 0; p < 3; p++) begin
      run(8'h4D, 0, 2'h1, 6'h02, 16'(p * 4 + 1), 0);
      exp_page(6'h02, 16'(p * 4 + 1), 0);
      chk_ok();
    end
    al = 16'h001E;
    run(8'h4D, 0, 2'h1, 6'h01, 16'h0000, 1);
    exp_page(6'h01, 16'h0000, 1);
    chk_ok();
    fl = 8'hAA;
    axw(lsr_pkg::LSR_OFF_FLCFG, {24'h0, fl}, r);
    evts(100);
    al = 16'h00FF;
    run(8'h4D, 0, 2'h1, 6'h02, 16'h0000, 0);
    exp_page(6'h02, 16'h0000, 0);
    chk_ok();
    axw(lsr_pkg::LSR_OFF_CTRL, 32'h2, r);
    foreach (mc[i]) mc[i] = 64'h0;
    chk("unit attention", 32'h1, unit_attn);
    axr(lsr_pkg::LSR_OFF_STAT, d, r);
    chk("status ua", 32'h1, d[lsr_pkg::LSR_ST_UA]);
    run(8'h4D, 0, 2'h1, 6'h02, 16'h0000, 0);
    exp_page(6'h02, 16'h0000, 0);
    chk_ok();
    axw(lsr_pkg::LSR_OFF_STAT, 32'h8, r);
    chk("unit attention", 32'h0, unit_attn);
    summarize();
  end
endmodule : log_sense_responder_tb
